// ===== shared/dsob_defines.svh
// Register offsets, field positions, reset values and timing counts of the override bank
`ifndef DSOB_DEFINES_SVH
`define DSOB_DEFINES_SVH

`define DSOB_ADDR_W 8
`define DSOB_DATA_W 16

`define DSOB_OFS_SIGNAL 8'he0
`define DSOB_OFS_REGULATOR 8'he1
`define DSOB_OFS_CHARGER 8'he2
`define DSOB_OFS_MASTER 8'he8
`define DSOB_OFS_IRQ_STS 8'he9
`define DSOB_OFS_IRQ_MASK 8'hea

`define DSOB_RST_SIGNAL 16'h0000
`define DSOB_RST_REGULATOR 16'h0000
`define DSOB_RST_CHARGER 16'h0000
`define DSOB_RST_MASTER 16'h0000
`define DSOB_RST_IRQ 16'h0000

// Comparator fields that read back raw and may be forced; writable master and interrupt mask bits
`define DSOB_CMP_SIGNAL_MASK 16'h0c8f
`define DSOB_CMP_REGULATOR_MASK 16'h8f3f
`define DSOB_CMP_CHARGER_MASK 16'hc807
`define DSOB_MASTER_MASK 16'h0001
`define DSOB_IRQ_MASK_BITS 16'h000f

`define DSOB_BIT_LOOP_LOCK 9
`define DSOB_BIT_TICK 8
`define DSOB_BIT_ALARM 6
`define DSOB_BIT_MASTER 0

`define DSOB_EV_SIGNAL 0
`define DSOB_EV_REGULATOR 1
`define DSOB_EV_CHARGER 2
`define DSOB_EV_SM_CLEAR 3

`define DSOB_CLK_HZ 40000000
`define DSOB_TICK16K_HZ 16000
`define DSOB_TICK_DIV (`DSOB_CLK_HZ / `DSOB_TICK16K_HZ)
`define DSOB_TICK_CNT_W 12

`endif

// ===== shared/dsob_pkg.sv
// Types shared by the override bank and its users
package dsob_pkg;

	// One raw or forced comparator set, one word per register
	typedef struct packed
	{
		logic [15:0] signal;
		logic [15:0] regulator;
		logic [15:0] charger;
	} dsob_cmp_t;

	typedef enum logic [1:0]
	{
		DSOB_EV_NONE = 2'h0,
		DSOB_EV_SEEN = 2'h1
	} dsob_ev_t;

endpackage : dsob_pkg

// ===== src/dsob_bank.sv
// Debounce signal override and observation register bank
//
// Summary of operation
// (RULE_01) Reading a comparator field returns the present raw, undebounced signal.
// (RULE_02) With master force set, written comparator values feed the debouncer.
// (RULE_03) Bit 9 set forces the loop-locked indication active.
// (RULE_04) Bit 8 set replaces every debounce tick with a 16KHz tick.
// (RULE_05) Bit 6 set drives the wake alarm to one; clear passes it.
// (RULE_06) Regulator status fields clear on power state machine clear and reset.
// (RULE_07) With master force clear, raw signals feed the debouncer unchanged.
`timescale 1ns/100ps
`include "dsob_defines.svh"

module dsob_bank
	import dsob_pkg::*;
#(
	parameter int TICK_W = 4
)
(
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic [`DSOB_ADDR_W-1:0] addr_in,
	input wire logic [`DSOB_DATA_W-1:0] wr_data_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	output logic [`DSOB_DATA_W-1:0] rd_data_out,
	input wire dsob_cmp_t raw_cmp_in,
	input wire logic pwr_sm_clear_in,
	input wire logic loop_lock_raw_in,
	input wire logic wake_alarm_raw_in,
	input wire logic [TICK_W-1:0] deb_ticks_in,
	output dsob_cmp_t deb_cmp_out,
	output logic [TICK_W-1:0] deb_ticks_out,
	output logic loop_lock_out,
	output logic wake_alarm_out,
	output logic irq_out
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------

	// Forced bits where allowed, raw bits elsewhere
	function automatic logic [15:0] dsob_merge
	(
		input logic [15:0] forced,
		input logic [15:0] raw,
		input logic [15:0] mask,
		input logic sel
	);
		logic [15:0] res;
		res = raw;
		if (sel)
		begin
			res = (forced & mask) | (raw & ~mask);
		end
		return res;
	endfunction : dsob_merge

	// Comparator fields read raw, control bits read stored
	function automatic logic [15:0] dsob_readback
	(
		input logic [15:0] stored,
		input logic [15:0] raw,
		input logic [15:0] mask
	);
		return (raw & mask) | (stored & ~mask);
	endfunction : dsob_readback

	// Event if any comparator bit moved
	function automatic logic dsob_moved
	(
		input logic [15:0] now,
		input logic [15:0] prev,
		input logic [15:0] mask
	);
		return |((now ^ prev) & mask);
	endfunction : dsob_moved

	// ----------------------------------------
	// Decode
	// ----------------------------------------

	logic wr_signal;
	logic wr_regulator;
	logic wr_charger;
	logic wr_master;
	logic wr_irq_sts;
	logic wr_irq_mask;

	assign wr_signal = wr_en_in && (addr_in == `DSOB_OFS_SIGNAL);
	assign wr_regulator = wr_en_in && (addr_in == `DSOB_OFS_REGULATOR);
	assign wr_charger = wr_en_in && (addr_in == `DSOB_OFS_CHARGER);
	assign wr_master = wr_en_in && (addr_in == `DSOB_OFS_MASTER);
	assign wr_irq_sts = wr_en_in && (addr_in == `DSOB_OFS_IRQ_STS);
	assign wr_irq_mask = wr_en_in && (addr_in == `DSOB_OFS_IRQ_MASK);

	// ----------------------------------------
	// Stored force values
	// ----------------------------------------

	logic [15:0] signal_force_bits_reg;
	logic [15:0] regulator_state_readback_reg;
	logic [15:0] charger_comparator_force_reg;
	logic [15:0] master_ctrl_reg;
	logic master_comparator_force;

	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			signal_force_bits_reg <= `DSOB_RST_SIGNAL;
		end
		else if (wr_signal)
		begin
			signal_force_bits_reg <= wr_data_in;
		end
	end

	// Power state machine clear outranks a software write in the same cycle
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			regulator_state_readback_reg <= `DSOB_RST_REGULATOR; // see RULE_06
		end
		else if (pwr_sm_clear_in)
		begin
			regulator_state_readback_reg <= `DSOB_RST_REGULATOR; // see RULE_06
		end
		else if (wr_regulator)
		begin
			regulator_state_readback_reg <= wr_data_in & `DSOB_CMP_REGULATOR_MASK;
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			charger_comparator_force_reg <= `DSOB_RST_CHARGER;
		end
		else if (wr_charger)
		begin
			charger_comparator_force_reg <= wr_data_in & `DSOB_CMP_CHARGER_MASK;
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			master_ctrl_reg <= `DSOB_RST_MASTER;
		end
		else if (wr_master)
		begin
			master_ctrl_reg <= wr_data_in & `DSOB_MASTER_MASK;
		end
	end

	assign master_comparator_force = master_ctrl_reg[`DSOB_BIT_MASTER];

	// ----------------------------------------
	// Debounce inputs
	// ----------------------------------------

	// Registered so the debouncer never sees a glitch from the mux
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			deb_cmp_out <= '0;
		end
		else
		begin
			deb_cmp_out.signal <= dsob_merge(signal_force_bits_reg, raw_cmp_in.signal,
				`DSOB_CMP_SIGNAL_MASK, master_comparator_force); // see RULE_02 see RULE_07
			deb_cmp_out.regulator <= dsob_merge(regulator_state_readback_reg,
				raw_cmp_in.regulator, `DSOB_CMP_REGULATOR_MASK,
				master_comparator_force); // see RULE_02 see RULE_07
			deb_cmp_out.charger <= dsob_merge(charger_comparator_force_reg,
				raw_cmp_in.charger, `DSOB_CMP_CHARGER_MASK,
				master_comparator_force); // see RULE_02 see RULE_07
		end
	end

	// ----------------------------------------
	// Loop lock and wake alarm
	// ----------------------------------------

	// These forces do not depend on the master force bit
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			loop_lock_out <= 1'b0;
		end
		else
		begin
			loop_lock_out <= loop_lock_raw_in
				| signal_force_bits_reg[`DSOB_BIT_LOOP_LOCK]; // see RULE_03
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			wake_alarm_out <= 1'b0;
		end
		else
		begin
			wake_alarm_out <= wake_alarm_raw_in
				| signal_force_bits_reg[`DSOB_BIT_ALARM]; // see RULE_05
		end
	end

	// ----------------------------------------
	// Debounce ticks
	// ----------------------------------------

	localparam logic [`DSOB_TICK_CNT_W-1:0] TICK_LAST =
		`DSOB_TICK_CNT_W'(`DSOB_TICK_DIV - 1);

	logic [`DSOB_TICK_CNT_W-1:0] tick_cnt_reg;
	logic tick16k;

	// Divider free-runs so the forced tick rate is exact from the first period
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			tick_cnt_reg <= '0;
		end
		else if (tick_cnt_reg == TICK_LAST)
		begin
			tick_cnt_reg <= '0;
		end
		else
		begin
			tick_cnt_reg <= tick_cnt_reg + 1'b1;
		end
	end

	assign tick16k = (tick_cnt_reg == TICK_LAST);

	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			deb_ticks_out <= '0;
		end
		else if (signal_force_bits_reg[`DSOB_BIT_TICK])
		begin
			deb_ticks_out <= {TICK_W{tick16k}}; // see RULE_04
		end
		else
		begin
			deb_ticks_out <= deb_ticks_in;
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------

	dsob_cmp_t raw_prev_reg;
	logic [15:0] irq_sts_reg;
	logic [15:0] irq_mask_reg;
	logic [15:0] irq_events;

	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			raw_prev_reg <= '0;
		end
		else
		begin
			raw_prev_reg <= raw_cmp_in;
		end
	end

	always_comb
	begin
		irq_events = '0;
		irq_events[`DSOB_EV_SIGNAL] = dsob_moved(raw_cmp_in.signal,
			raw_prev_reg.signal, `DSOB_CMP_SIGNAL_MASK);
		irq_events[`DSOB_EV_REGULATOR] = dsob_moved(raw_cmp_in.regulator,
			raw_prev_reg.regulator, `DSOB_CMP_REGULATOR_MASK);
		irq_events[`DSOB_EV_CHARGER] = dsob_moved(raw_cmp_in.charger,
			raw_prev_reg.charger, `DSOB_CMP_CHARGER_MASK);
		irq_events[`DSOB_EV_SM_CLEAR] = pwr_sm_clear_in;
	end

	// Set wins over a write-one-to-clear in the same cycle
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			irq_sts_reg <= `DSOB_RST_IRQ;
		end
		else if (wr_irq_sts)
		begin
			irq_sts_reg <= (irq_sts_reg & ~wr_data_in) | irq_events;
		end
		else
		begin
			irq_sts_reg <= irq_sts_reg | irq_events;
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			irq_mask_reg <= `DSOB_RST_IRQ;
		end
		else if (wr_irq_mask)
		begin
			irq_mask_reg <= wr_data_in & `DSOB_IRQ_MASK_BITS;
		end
	end

	assign irq_out = |(irq_sts_reg & irq_mask_reg);

	// ----------------------------------------
	// Read port
	// ----------------------------------------

	logic [15:0] rd_value;

	always_comb
	begin
		case (addr_in)
			`DSOB_OFS_SIGNAL:
			begin
				rd_value = dsob_readback(signal_force_bits_reg, raw_cmp_in.signal,
					`DSOB_CMP_SIGNAL_MASK); // see RULE_01
			end
			`DSOB_OFS_REGULATOR:
			begin
				rd_value = dsob_readback(regulator_state_readback_reg,
					raw_cmp_in.regulator, `DSOB_CMP_REGULATOR_MASK); // see RULE_01
			end
			`DSOB_OFS_CHARGER:
			begin
				rd_value = dsob_readback(charger_comparator_force_reg,
					raw_cmp_in.charger, `DSOB_CMP_CHARGER_MASK); // see RULE_01
			end
			`DSOB_OFS_MASTER:
			begin
				rd_value = master_ctrl_reg;
			end
			`DSOB_OFS_IRQ_STS:
			begin
				rd_value = irq_sts_reg;
			end
			`DSOB_OFS_IRQ_MASK:
			begin
				rd_value = irq_mask_reg;
			end
			default:
			begin
				rd_value = 16'h0000;
			end
		endcase
	end

	// Data stand only in the cycle after the strobe
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			rd_data_out <= '0;
		end
		else if (rd_en_in)
		begin
			rd_data_out <= rd_value;
		end
		else
		begin
			rd_data_out <= '0;
		end
	end

endmodule : dsob_bank

// ===== test/dsob_bank_checker.sv
// Port-level assertions for the override bank
`timescale 1ns/100ps
`include "dsob_defines.svh"

module dsob_bank_checker
	import dsob_pkg::*;
#(
	parameter int TICK_W = 4
)
(
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic [`DSOB_ADDR_W-1:0] addr_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire logic [`DSOB_DATA_W-1:0] rd_data_out,
	input wire dsob_cmp_t raw_cmp_in,
	input wire logic pwr_sm_clear_in,
	input wire logic loop_lock_raw_in,
	input wire logic wake_alarm_raw_in,
	input wire logic [TICK_W-1:0] deb_ticks_in,
	input wire dsob_cmp_t deb_cmp_out,
	input wire logic [TICK_W-1:0] deb_ticks_out,
	input wire logic loop_lock_out,
	input wire logic wake_alarm_out,
	input wire logic irq_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (sys_rst_in);

	property p_rd_idle;
		!rd_en_in |=> rd_data_out == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not zero when idle");
	property p_rd_gap;
		rd_en_in && !(addr_in inside {8'he0, 8'he1, 8'he2, 8'he8, 8'he9, 8'hea})
			|=> rd_data_out == 16'h0000;
	endproperty
	a_rd_gap: assert property (p_rd_gap)
		else $error("unmapped read not zero");
	property p_rd_sig;
		rd_en_in && addr_in == 8'he0
			|=> (rd_data_out & 16'h0c8f) == ($past(raw_cmp_in.signal) & 16'h0c8f);
	endproperty
	a_rd_sig: assert property (p_rd_sig)
		else $error("signal readback not raw");
	property p_rd_reg;
		rd_en_in && addr_in == 8'he1 |=> rd_data_out == ($past(raw_cmp_in.regulator) & 16'h8f3f);
	endproperty
	a_rd_reg: assert property (p_rd_reg)
		else $error("regulator readback not raw");
	// Bits outside the comparator mask are never forced, master or not
	property p_deb_pass;
		!$past(sys_rst_in)
			|-> (deb_cmp_out.signal & ~16'h0c8f) == ($past(raw_cmp_in.signal) & ~16'h0c8f);
	endproperty
	a_deb_pass: assert property (p_deb_pass)
		else $error("unforced signal bits differ from raw");
	property p_lock;
		loop_lock_raw_in |=> loop_lock_out;
	endproperty
	a_lock: assert property (p_lock)
		else $error("loop lock lost");
	property p_alarm;
		wake_alarm_raw_in |=> wake_alarm_out;
	endproperty
	a_alarm: assert property (p_alarm)
		else $error("wake alarm lost");
	property p_ticks;
		!$past(sys_rst_in) |-> deb_ticks_out == $past(deb_ticks_in) || deb_ticks_out == '0
			|| &deb_ticks_out;
	endproperty
	a_ticks: assert property (p_ticks)
		else $error("tick output neither normal nor forced");
	// Once cleared, a regulator field feeds either zero or its raw level, never a stale force
	property p_clr;
		pwr_sm_clear_in ##1 !wr_en_in |=>
			(deb_cmp_out.regulator & 16'h8f3f & ~$past(raw_cmp_in.regulator)) == 16'h0000;
	endproperty
	a_clr: assert property (p_clr)
		else $error("regulator force kept after clear");

	c_irq: cover property (irq_out);
	c_tick: cover property (&deb_ticks_out);
	c_clr: cover property (pwr_sm_clear_in);
endmodule : dsob_bank_checker

bind dsob_bank dsob_bank_checker #(.TICK_W(TICK_W)) u_chk (.clk_sys_in, .sys_rst_in, .addr_in,
	.wr_en_in, .rd_en_in, .rd_data_out, .raw_cmp_in, .pwr_sm_clear_in, .loop_lock_raw_in,
	.wake_alarm_raw_in,
	.deb_ticks_in, .deb_cmp_out, .deb_ticks_out, .loop_lock_out, .wake_alarm_out, .irq_out);

// ===== test/tb.sv
// Self-checking bench for the override bank
`timescale 1ns/100ps
`include "dsob_defines.svh"

module tb
	import dsob_pkg::*;
;
	logic clk_sys_in = 0, sys_rst_in = 1, wr_en_in = 0, rd_en_in = 0, pwr_sm_clear_in = 0;
	logic loop_lock_raw_in = 0, wake_alarm_raw_in = 0, loop_lock_out, wake_alarm_out, irq_out;
	logic [7:0] addr_in = 8'h00;
	logic [15:0] wr_data_in = 16'h0000, rd_data_out;
	logic [3:0] deb_ticks_in = 4'h0, deb_ticks_out;
	dsob_cmp_t raw_cmp_in = '0, deb_cmp_out;
	logic [7:0] regs [7] = '{8'he0, 8'he1, 8'he2, 8'he8, 8'he9, 8'hea, 8'h50};
	int n_mismatch = 0, samples_checked = 0, cyc = 0, n_hi = 0, n_bad = 0;

	always #12.5 clk_sys_in = ~clk_sys_in;

	dsob_bank #(.TICK_W(4)) DUT (.clk_sys_in, .sys_rst_in, .addr_in, .wr_data_in, .wr_en_in,
		.rd_en_in, .rd_data_out, .raw_cmp_in, .pwr_sm_clear_in, .loop_lock_raw_in,
		.wake_alarm_raw_in, .deb_ticks_in, .deb_cmp_out, .deb_ticks_out, .loop_lock_out,
		.wake_alarm_out, .irq_out);

	// -----------------------------------------------
	// Bus and check tasks
	// -----------------------------------------------
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys_in);
		wr_en_in <= 1'b1;
		addr_in <= a;
		wr_data_in <= d;
		@(posedge clk_sys_in);
		wr_en_in <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk_sys_in);
		rd_en_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_sys_in);
		rd_en_in <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), rd_data_out, e);
	endtask : rd
	task automatic settle;
		repeat (2) @(posedge clk_sys_in);
		#1;
	endtask : settle

	always @(posedge clk_sys_in)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			test_done();
		end
	end

	// -----------------------------------------------
	// Main sequence
	// -----------------------------------------------
	initial
	begin
		repeat (20) @(posedge clk_sys_in);
		sys_rst_in <= 1'b0;
		foreach (regs[i]) rd(regs[i], 16'h0000);
		@(posedge clk_sys_in);
		raw_cmp_in.signal <= 16'hf075;
		raw_cmp_in.regulator <= 16'h4001;
		wr(8'he0, 16'h0888);
		settle();
		chk("deb signal", deb_cmp_out.signal, 16'hf075);
		rd(8'he0, 16'h0005);
		rd(8'he1, 16'h0001);
		rd(8'he9, 16'h0003);
		wr(8'hea, 16'h0001);
		#1;
		chk("irq_out", irq_out, 1'b1);
		wr(8'he9, 16'h0001);
		#1;
		chk("irq_out", irq_out, 1'b0);
		wr(8'he8, 16'h0001);
		wr(8'he1, 16'h8f3e);
		wr(8'he2, 16'hc807);
		settle();
		chk("deb signal", deb_cmp_out.signal, 16'hf8f8);
		chk("deb regulator", deb_cmp_out.regulator, 16'hcf3e);
		chk("deb charger", deb_cmp_out.charger, 16'hc807);
		@(posedge clk_sys_in);
		pwr_sm_clear_in <= 1'b1;
		@(posedge clk_sys_in);
		pwr_sm_clear_in <= 1'b0;
		settle();
		chk("deb regulator", deb_cmp_out.regulator, 16'h4000);
		rd(8'he9, 16'h000a);
		wr(8'he8, 16'h0000);
		settle();
		chk("deb charger", deb_cmp_out.charger, 16'h0000);
		wr(8'he0, 16'h0240);
		settle();
		chk("loop_lock_out", loop_lock_out, 1'b1);
		chk("wake_alarm_out", wake_alarm_out, 1'b1);
		rd(8'he0, 16'h0245);
		wr(8'he0, 16'h0000);
		settle();
		chk("loop_lock_out", loop_lock_out, 1'b0);
		chk("wake_alarm_out", wake_alarm_out, 1'b0);
		@(posedge clk_sys_in);
		wake_alarm_raw_in <= 1'b1;
		loop_lock_raw_in <= 1'b1;
		raw_cmp_in.charger <= 16'hc84b;
		deb_ticks_in <= 4'h5;
		settle();
		chk("wake_alarm_out", wake_alarm_out, 1'b1);
		chk("loop_lock_out", loop_lock_out, 1'b1);
		chk("deb_ticks_out", deb_ticks_out, 4'h5);
		rd(8'he2, 16'hc803);
		wr(8'he0, 16'h0100);
		settle();
		// Two whole divider periods hold exactly two forced pulses
		repeat (5000)
		begin
			@(posedge clk_sys_in);
			#1;
			if (deb_ticks_out === 4'hf)
				n_hi++;
			else if (deb_ticks_out !== 4'h0)
				n_bad++;
		end
		chk("forced ticks", 16'(n_hi), 16'h0002);
		chk("stray ticks", 16'(n_bad), 16'h0000);
		test_done();
	end
endmodule : tb
